// ==== rsc_startup_ctl.sv ====
// Purpose: start-up, reference ramp and stop sequencing of a step-down regulator
// Assumes: outputSense is a millivolt word on clk; other pins are asynchronous
// Notes:   serial bus runs on linkClk and reaches the registers by a toggle handshake
// Operation
// - bus answers only after full initialisation
// - fixed read-only part code at 0x04
// - bus_level_config bit 1 selects bus voltage range
// - base target address register, default 0x08
// - start-up offset 0..3 added to base
// - pin resistance decoded to offset 0..3
// - bias good: leave reset, load, find offset
// - ramp starts after init and enable
// - ramp rate 1 or 2 mV/us by bit 3
// - minimum on-time first, then lengthened
// - 9-bit target code over 0x12 and 0x13
// - target equals code steps plus 0.8 V
// - current and voltage protection during ramp
// - pre-charged output: drives off until crossed
// - power good waits for first pulse
// - enable low: drives off, levels zero
// - both stop bits: ramp down, then off
// - stop bits reset to zero
module rsc_startup_ctl
	import rsc_pkg::*;
#(
	parameter logic [7:0] PART_IDENTIFICATION    = 8'h5a,  // arbitrary identity value
	parameter int         PWM_PERIOD = 19,     // switching period in clk cycles
	parameter int         MIN_ON     = 2       // minimum on-time in clk cycles
) (
	// clocks and reset
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic            linkClk,
	// supply, enable and address pins
	input  wire logic            biasUndervoltageLockout,
	input  wire logic            enable,
	input  wire logic [2:0]      addrCmp,
	// protection and sensing
	input  wire logic            ocpFault,
	input  wire logic            ovpFault,
	input  wire logic [MV_W-1:0] outputSense,
	// serial bus
	input  wire logic            sclIn,
	input  wire logic            sdaIn,
	output logic                 sdaOut,
	output logic                 sdaOe_n,
	// power stage
	output logic                 highSideDrive,
	output logic                 lowSideDrive,
	output logic [MV_W-1:0]      refLevel,
	output logic                 powerGoodOut,
	output logic                 powerGoodOe_n,
	output logic                 busLevelSel
);
	localparam int PW = $clog2(PWM_PERIOD + 1);

	// refuse periods the counters cannot hold
	if (PWM_PERIOD > 32 || MIN_ON < 1 || MIN_ON > PWM_PERIOD - 2) begin : g_chk
		$error("rsc_startup_ctl: bad PWM_PERIOD or MIN_ON");
	end

	// synchronised pins
	logic [6:0] pinS;
	wire        enS   = pinS[6];
	wire        ocpS  = pinS[5];
	wire        ovpS  = pinS[4];
	wire        uvloS = pinS[3];
	wire [2:0]  addrS = pinS[2:0];

	rsc_sync #(.W(7)) uPinSync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({enable, ocpFault, ovpFault, biasUndervoltageLockout, addrCmp}),
		.q      (pinS)
	);

	// link handshake
	logic       reqTgl, reqWr;     // from the link, held until answered
	logic [7:0] reqIdx, reqData;
	logic       reqS, reqSeen_r;   // synchronised request toggle
	logic       ackTgl_r;          // answer toggle
	logic [7:0] rdData_r;          // read answer, stable until next request
	logic       ready_r;           // bus open
	logic [6:0] devAddr_r;         // latched target address

	rsc_sync #(.W(1)) uReqSync (
		.clk    (clk),
		.resetn (resetn),
		.d      (reqTgl),
		.q      (reqS)
	);

	rsc_i2c_target uLink (
		.linkClk  (linkClk),
		.resetn   (resetn),
		.sclIn    (sclIn),
		.sdaIn    (sdaIn),
		.sdaOut   (sdaOut),
		.sdaOe_n  (sdaOe_n),
		.busReady (ready_r),
		.ackTgl   (ackTgl_r),
		.rdData   (rdData_r),
		.devAddr  (devAddr_r),
		.reqTgl   (reqTgl),
		.reqWr    (reqWr),
		.reqIdx   (reqIdx),
		.reqData  (reqData)
	);

	// registers
	rsc_state_t state_r, state_nxt;
	logic [2:0] loadCnt_r;        // non-volatile load cycles
	logic [8:0] vout_r;           // target code
	logic [7:0] ramp_r;           // ramp control
	logic [7:0] busLvl_r;         // bus level config
	logic [7:0] stop_r;           // stop config
	logic [7:0] base_r;           // base target address

	// ramp and switching state
	logic [MV_W-1:0]       ssLvl_r, ssLvl_nxt;
	logic [RAMP_CNT_W-1:0] usCnt_r;
	logic                  switchEn_r;   // pre-bias gate open
	logic                  firstPulse_r; // a high-side pulse has been issued
	logic [PW-1:0]         pwmCnt_r, onCyc_r;
	logic                  pg_r;

	// decode of the link request
	wire reqEdge = reqS ^ reqSeen_r;
	wire wrEn    = reqEdge & reqWr & ready_r;

	// read data selection, unmapped reads as zero
	wire [7:0] rdMux =
		(reqIdx == IDX_PART_IDENTIFICATION) ? PART_IDENTIFICATION :
		(reqIdx == IDX_VOUT_HI) ? {7'h00, vout_r[8]} :
		(reqIdx == IDX_VOUT_LO) ? vout_r[7:0] :
		(reqIdx == IDX_RAMP)    ? ramp_r :
		(reqIdx == IDX_BUSLVL)  ? busLvl_r :
		(reqIdx == IDX_STOP)    ? stop_r :
		(reqIdx == IDX_BASE)    ? base_r : 8'h00;

	// offset from the thermometer of the address ladder
	wire [1:0] addrOff = addrS[2] ? 2'd3 : addrS[1] ? 2'd2 : addrS[0] ? 2'd1 : 2'd0;

	// target level: code times 10 mV plus 0.8 V
	wire [MV_W-1:0] tgtMv = MV_W'(vout_r * VOUT_STEP_MV) + VOUT_OFFSET_MV;

	// ramp step and tick
	wire [MV_W-1:0] stepMv = ramp_r[RAMP_RATE_BIT] ? RATE_FAST_MV : RATE_SLOW_MV;
	wire            tick   = (usCnt_r == RAMP_CNT_W'(RAMP_STEP_CYC - 1));

	// graceful stop needs both bits; host keeps the arm steady while running
	wire stopReq = ramp_r[RAMP_GSTOP_BIT] & stop_r[STOP_ARM_BIT];

	wire active    = (state_r == ST_RAMP) || (state_r == ST_RUN) || (state_r == ST_DOWN);
	wire activeNxt = (state_nxt == ST_RAMP) || (state_nxt == ST_RUN) ||
	                 (state_nxt == ST_DOWN);

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: if (!uvloS) state_nxt = ST_LOAD;
			ST_LOAD:  if (loadCnt_r == 3'(NVM_LOAD_CYC - 1)) state_nxt = ST_ADDR;
			ST_ADDR:  state_nxt = ST_IDLE;
			ST_IDLE:  if (enS && !stopReq) state_nxt = ST_RAMP;
			ST_RAMP: begin
				if (stopReq) state_nxt = ST_DOWN;
				else if (ssLvl_r == tgtMv) state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (stopReq) state_nxt = ST_DOWN;
				else if (ssLvl_r != tgtMv) state_nxt = ST_RAMP;        // new target
			end
			ST_DOWN: begin
				if (ssLvl_r == '0) state_nxt = ST_IDLE;
				else if (!stopReq) state_nxt = ST_RAMP;
			end
			default: state_nxt = ST_RESET;
		endcase
		if (active && !enS) state_nxt = ST_IDLE;
		if (uvloS) state_nxt = ST_RESET;
	end

	// soft-start level next value
	always_comb begin
		ssLvl_nxt = ssLvl_r;
		if (!active || !enS || uvloS) begin
			ssLvl_nxt = '0;
		end else if (tick && state_r == ST_DOWN) begin
			ssLvl_nxt = (ssLvl_r > stepMv) ? ssLvl_r - stepMv : '0;
		end else if (tick && ssLvl_r < tgtMv) begin
			ssLvl_nxt = (tgtMv - ssLvl_r > stepMv) ? ssLvl_r + stepMv : tgtMv;
		end else if (tick && ssLvl_r > tgtMv) begin
			ssLvl_nxt = (ssLvl_r - tgtMv > stepMv) ? ssLvl_r - stepMv : tgtMv;
		end
	end

	// sequencer, ready and address latch
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r   <= ST_RESET;
			loadCnt_r <= 3'h0;
			ready_r   <= 1'b0;
			devAddr_r <= 7'h00;
		end else begin
			state_r   <= state_nxt;
			loadCnt_r <= (state_r == ST_LOAD) ? loadCnt_r + 3'h1 : 3'h0;
			// open only once loaded and the offset is known
			ready_r   <= (state_nxt != ST_RESET) && (state_nxt != ST_LOAD) &&
			             (state_nxt != ST_ADDR);
			if (state_r == ST_ADDR)
				devAddr_r <= base_r[6:0] + 7'(addrOff);
		end
	end

	// register file: defaults at reset and on load, then bus writes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			vout_r   <= VOUT_CODE_RST;
			ramp_r   <= RAMP_RST;
			busLvl_r <= BUSLVL_RST;
			stop_r   <= STOP_RST;
			base_r   <= BASE_ADDR_RST;
		end else if (state_r == ST_LOAD && loadCnt_r == 3'h0) begin
			vout_r   <= VOUT_CODE_RST;
			ramp_r   <= RAMP_RST;
			busLvl_r <= BUSLVL_RST;
			stop_r   <= STOP_RST;
			base_r   <= BASE_ADDR_RST;
		end else if (wrEn) begin
			case (reqIdx)
				IDX_VOUT_HI: vout_r[8]   <= reqData[VOUT_HI_BIT];
				IDX_VOUT_LO: vout_r[7:0] <= reqData;
				IDX_RAMP:    ramp_r      <= reqData;
				IDX_BUSLVL:  busLvl_r    <= reqData;
				IDX_STOP:    stop_r      <= reqData;
				IDX_BASE:    base_r      <= reqData;
				default:     ;                                         // part code read-only
			endcase
		end
	end

	// answer every request, reads capture the addressed register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reqSeen_r <= 1'b0;
			ackTgl_r  <= 1'b0;
			rdData_r  <= 8'h00;
		end else begin
			reqSeen_r <= reqS;
			if (reqEdge) begin
				ackTgl_r <= ~ackTgl_r;
				if (!reqWr) rdData_r <= rdMux;
			end
		end
	end

	// ramp tick and level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			usCnt_r <= '0;
			ssLvl_r <= '0;
		end else begin
			usCnt_r <= (!active || tick) ? '0 : usCnt_r + 1'b1;
			ssLvl_r <= ssLvl_nxt;
		end
	end

	// switching: gate opens once the level passes the sensed output
	wire drvAllow = switchEn_r & enS & ~ocpS & ~ovpS & active;
	wire hsNxt    = drvAllow & (pwmCnt_r < onCyc_r);
	wire lsNxt    = drvAllow & firstPulse_r & ~hsNxt;
	wire perEnd   = (pwmCnt_r == PW'(PWM_PERIOD - 1));

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			switchEn_r    <= 1'b0;
			firstPulse_r  <= 1'b0;
			pwmCnt_r      <= '0;
			onCyc_r       <= PW'(MIN_ON);
			highSideDrive <= 1'b0;
			lowSideDrive  <= 1'b0;
			pg_r          <= 1'b0;
		end else begin
			switchEn_r <= activeNxt && (switchEn_r || ssLvl_r > outputSense);
			firstPulse_r <= switchEn_r && (firstPulse_r || highSideDrive);
			pwmCnt_r <= perEnd ? '0 : pwmCnt_r + 1'b1;
			if (!switchEn_r)
				onCyc_r <= PW'(MIN_ON);
			else if (perEnd && outputSense < ssLvl_r && onCyc_r < PW'(PWM_PERIOD - 1))
				onCyc_r <= onCyc_r + 1'b1;
			else if (perEnd && outputSense > ssLvl_r && onCyc_r > PW'(MIN_ON))
				onCyc_r <= onCyc_r - 1'b1;
			highSideDrive <= hsNxt;
			lowSideDrive  <= lsNxt;
			pg_r <= firstPulse_r && (state_r == ST_RUN);
		end
	end

	// outputs
	assign refLevel      = ssLvl_r;
	assign busLevelSel   = busLvl_r[BUSLVL_SEL_BIT];
	assign powerGoodOut  = 1'b0;
	assign powerGoodOe_n = pg_r;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_uvlo_quiet;
		uvloS |=> state_r == ST_RESET && !ready_r && ssLvl_r == '0;
	endproperty
	a_uvlo_quiet: assert property (p_uvlo_quiet) else $error("reset not quiet");

	property p_ready_after_addr;
		$rose(ready_r) |-> $past(state_r) == ST_ADDR;
	endproperty
	a_ready_after_addr: assert property (p_ready_after_addr) else $error("early ready");

	property p_offset3;
		state_r == ST_ADDR && (addrS == 3'b000 || addrS == 3'b001 || addrS == 3'b011 ||
		addrS == 3'b111) |=> devAddr_r == base_r[6:0] + 7'($countones($past(addrS)));
	endproperty
	a_offset3: assert property (p_offset3) else $error("bad offset");

	property p_part_identification;
		reqEdge && !reqWr && reqIdx == IDX_PART_IDENTIFICATION |=> rdData_r == PART_IDENTIFICATION;
	endproperty
	a_part_identification: assert property (p_part_identification) else $error("bad part code");

	property p_no_start;
		state_r == ST_IDLE && !enS |=> state_r != ST_RAMP;
	endproperty
	a_no_start: assert property (p_no_start) else $error("ramp without enable");

	property p_ramp_step;
		state_r == ST_RAMP && tick && enS && !uvloS && tgtMv > ssLvl_r + 13'h004
		|=> ssLvl_r == $past(ssLvl_r) + $past(stepMv);
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("bad ramp step");

	property p_hard_stop;
		active && !enS |=> ssLvl_r == '0 && !highSideDrive && !lowSideDrive ##1 state_r == ST_IDLE;
	endproperty
	a_hard_stop: assert property (p_hard_stop) else $error("hard stop late");

	property p_prebias;
		$rose(switchEn_r) |-> $past(ssLvl_r) > $past(outputSense);
	endproperty
	a_prebias: assert property (p_prebias) else $error("gate opened early");

	property p_low_after_high;
		!firstPulse_r |-> ##1 !lowSideDrive;
	endproperty
	a_low_after_high: assert property (p_low_after_high) else $error("low side first");

	property p_pg_wait;
		$rose(pg_r) |-> $past(firstPulse_r);
	endproperty
	a_pg_wait: assert property (p_pg_wait) else $error("power good early");

	property p_soft_off;
		state_r == ST_DOWN && ssLvl_r == '0 |=> !switchEn_r ##1 !highSideDrive;
	endproperty
	a_soft_off: assert property (p_soft_off) else $error("drives on at zero");
endmodule : rsc_startup_ctl

// ==== rsc_pkg.sv ====
// Purpose: shared constants and types of the regulator start-up control
// Assumes: 25 MHz system clock; levels held in millivolts
// Notes:   register indices are the bus-visible indices of the register map
package rsc_pkg;
	// clock and ramp timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int RAMP_STEP_US  = 1;          // one ramp step per microsecond
	localparam int RAMP_STEP_CYC = (CLK_HZ / 1_000_000) * RAMP_STEP_US;
	localparam int RAMP_CNT_W    = $clog2(RAMP_STEP_CYC + 1);

	// register indices
	localparam logic [7:0] IDX_PART_IDENTIFICATION = 8'h04;
	localparam logic [7:0] IDX_VOUT_HI = 8'h12;
	localparam logic [7:0] IDX_VOUT_LO = 8'h13;
	localparam logic [7:0] IDX_RAMP    = 8'h14;
	localparam logic [7:0] IDX_BUSLVL  = 8'h1a;
	localparam logic [7:0] IDX_STOP    = 8'h1c;
	localparam logic [7:0] IDX_BASE    = 8'h1e;

	// field positions
	localparam int VOUT_HI_BIT    = 0;
	localparam int RAMP_GSTOP_BIT = 2;         // graceful_stop_ctl
	localparam int RAMP_RATE_BIT  = 3;
	localparam int BUSLVL_SEL_BIT = 1;
	localparam int STOP_ARM_BIT   = 3;         // graceful_stop_arm

	// reset and non-volatile default values
	localparam logic [7:0] BASE_ADDR_RST = 8'h08;
	localparam logic [8:0] VOUT_CODE_RST = 9'h0fa;
	localparam logic [7:0] RAMP_RST      = 8'h00;
	localparam logic [7:0] BUSLVL_RST    = 8'h00;
	localparam logic [7:0] STOP_RST      = 8'h00;
	localparam int         NVM_LOAD_CYC  = 5;

	// output level arithmetic, millivolts
	localparam int          MV_W           = 13;
	localparam logic [12:0] VOUT_STEP_MV   = 13'h00a;  // 10 mV per code
	localparam logic [12:0] VOUT_OFFSET_MV = 13'h320;  // 0.4 x 0.01 / 0.005 V
	localparam logic [12:0] RATE_SLOW_MV   = 13'h001;
	localparam logic [12:0] RATE_FAST_MV   = 13'h002;

	// sequencer states, gray along reset-load-address-idle-ramp-run
	typedef enum logic [2:0] {
		ST_RESET = 3'b000, ST_LOAD = 3'b001, ST_ADDR = 3'b011, ST_IDLE = 3'b010,
		ST_RAMP  = 3'b110, ST_RUN  = 3'b111, ST_DOWN = 3'b101
	} rsc_state_t;

	// serial target phases
	typedef enum logic [2:0] {
		I_IDLE = 3'b000, I_ADDR = 3'b001, I_RX = 3'b011, I_ACK = 3'b010,
		I_TX   = 3'b110, I_RACK = 3'b111
	} rsc_i2c_t;
endpackage : rsc_pkg

// ==== rsc_sync.sv ====
// Purpose: two-flop level synchroniser
// Assumes: inputs are quasi-static levels or toggles
// Notes:   only the second flop is visible outside
module rsc_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// level in and out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;  // first stage, read by q only

	// two stages, no logic between
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : rsc_sync

// ==== rsc_i2c_target.sv ====
// Purpose: serial bus target on the link clock, register index then data
// Assumes: link clock well above the bus clock; open-drain data line
// Notes:   reads are fetched ahead so data waits at the next falling edge
module rsc_i2c_target
	import rsc_pkg::*;
(
	// link clock and reset
	input  wire logic       linkClk,
	input  wire logic       resetn,
	// bus pins
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe_n,
	// from the system domain
	input  wire logic       busReady,
	input  wire logic       ackTgl,
	input  wire logic [7:0] rdData,
	input  wire logic [6:0] devAddr,
	// requests to the system domain
	output logic            reqTgl,
	output logic            reqWr,
	output logic [7:0]      reqIdx,
	output logic [7:0]      reqData
);
	logic       rdyS, ackS, sclS, sdaS;   // synchronised inputs
	logic       sclPrev_r, sdaPrev_r;     // last samples for edges
	rsc_i2c_t   ph_r;                     // transfer phase
	logic [3:0] bitCnt_r;                 // bits of this byte
	logic [7:0] sh_r;                     // shift register
	logic       rw_r;                     // read transfer
	logic       haveIdx_r;                // index byte seen
	logic [7:0] idx_r;                    // running register index
	logic       sdaLow_r;                 // pull data low

	rsc_sync #(.W(4)) uSync (
		.clk    (linkClk),
		.resetn (resetn),
		.d      ({busReady, ackTgl, sclIn, sdaIn}),
		.q      ({rdyS, ackS, sclS, sdaS})
	);

	// bus conditions from the sampled pins
	wire sclRise = sclS & ~sclPrev_r;
	wire sclFall = ~sclS & sclPrev_r;
	wire startC  = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
	wire stopC   = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
	wire addrHit = (sh_r[7:1] == devAddr);

	assign sdaOut  = 1'b0;
	assign sdaOe_n = ~sdaLow_r;

	// phase machine; requests toggle reqTgl, one in flight per byte
	always_ff @(posedge linkClk or negedge resetn) begin
		if (!resetn) begin
			{sclPrev_r, sdaPrev_r, rw_r, haveIdx_r, sdaLow_r} <= '0;
			{reqTgl, reqWr, reqIdx, reqData, idx_r, sh_r} <= '0;
			ph_r     <= I_IDLE;
			bitCnt_r <= 4'h0;
		end else begin
			sclPrev_r <= sclS;
			sdaPrev_r <= sdaS;
			if (stopC || !rdyS) begin        // not ready: bus ignored
				ph_r     <= I_IDLE;
				sdaLow_r <= 1'b0;
			end else if (startC) begin
				ph_r      <= I_ADDR;
				bitCnt_r  <= 4'h0;
				haveIdx_r <= 1'b0;
				sdaLow_r  <= 1'b0;
			end else if (sclRise) begin
				if (ph_r == I_ADDR || ph_r == I_RX) begin
					sh_r     <= {sh_r[6:0], sdaS};
					bitCnt_r <= bitCnt_r + 4'h1;
				end else if (ph_r == I_RACK && sdaS) begin
					ph_r <= I_IDLE;            // no acknowledge ends the read
				end
			end else if (sclFall) begin
				case (ph_r)
					I_ADDR: if (bitCnt_r == 4'h8) begin
						if (addrHit) begin
							sdaLow_r <= 1'b1;
							rw_r     <= sh_r[0];
							ph_r     <= I_ACK;
							reqTgl   <= ~reqTgl; // fetch current index
							reqWr    <= 1'b0;
							reqIdx   <= idx_r;
						end else begin
							ph_r <= I_IDLE;
						end
					end
					I_RX: if (bitCnt_r == 4'h8) begin
						sdaLow_r <= 1'b1;
						ph_r     <= I_ACK;
						reqTgl   <= ~reqTgl;
						if (!haveIdx_r) begin   // index byte
							idx_r     <= sh_r;
							haveIdx_r <= 1'b1;
							reqWr     <= 1'b0;
							reqIdx    <= sh_r;
						end else begin          // data byte
							reqWr   <= 1'b1;
							reqIdx  <= idx_r;
							reqData <= sh_r;
							idx_r   <= idx_r + 8'h01;
						end
					end
					I_ACK: begin
						bitCnt_r <= 4'h0;
						if (rw_r) begin
							sh_r     <= rdData;
							sdaLow_r <= ~rdData[7];
							bitCnt_r <= 4'h1;
							ph_r     <= I_TX;
						end else begin
							sdaLow_r <= 1'b0;
							ph_r     <= I_RX;
						end
					end
					I_TX: if (bitCnt_r == 4'h8) begin
						sdaLow_r <= 1'b0;
						ph_r     <= I_RACK;
						idx_r    <= idx_r + 8'h01;
						reqTgl   <= ~reqTgl;    // fetch ahead
						reqWr    <= 1'b0;
						reqIdx   <= idx_r + 8'h01;
					end else begin
						sdaLow_r <= ~sh_r[6];
						sh_r     <= {sh_r[6:0], 1'b0};
						bitCnt_r <= bitCnt_r + 4'h1;
					end
					I_RACK: begin
						sh_r     <= rdData;
						sdaLow_r <= ~rdData[7];
						bitCnt_r <= 4'h1;
						ph_r     <= I_TX;
					end
					default: ph_r <= I_IDLE;
				endcase
			end
		end
	end

	// ackS is kept synchronised for completeness of the handshake
	wire unusedAck = ackS;
endmodule : rsc_i2c_target

// ==== rsc_i2c_master.sv ====
// Purpose: bus master model for the regulator's serial target
// Assumes: SDA pulled up; SCL driven by this model alone
// Notes:   SCL low 4 and high 6 link cycles, so no stretching is needed
module rsc_i2c_master (
	// link clock
	input  wire logic linkClk,
	// bus pins
	input  wire logic sda,
	output logic      scl = 1'b1,
	output logic      sdaOe_n = 1'b1
);
	timeunit 1ns;
	timeprecision 1ns;
	// wait whole link cycles
	task automatic w(input int n);
		repeat (n) @(posedge linkClk);
	endtask : w
	// one bit; SDA moves a cycle after SCL falls so it never looks like a stop
	task automatic bt(input logic b, output logic r);
		w(1);
		sdaOe_n <= b;
		w(3);
		scl <= 1'b1;
		w(3);
		r = sda;
		w(3);
		scl <= 1'b0;
	endtask : bt
	// start, also used as repeated start
	task automatic st();
		w(1);
		sdaOe_n <= 1'b1;
		w(3);
		scl <= 1'b1;
		w(4);
		sdaOe_n <= 1'b0;
		w(4);
		scl <= 1'b0;
	endtask : st
	// stop leaves both lines released
	task automatic sp();
		w(1);
		sdaOe_n <= 1'b0;
		w(3);
		scl <= 1'b1;
		w(4);
		sdaOe_n <= 1'b1;
		w(6);
	endtask : sp
	// byte msb first; ninth bit c released reads the answer into a
	task automatic xb(input logic [7:0] d, input logic c, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], r[i]);
		end
		bt(c, a);
	endtask : xb
	// index then data write
	task automatic wr(input logic [6:0] ad, input logic [7:0] ix, dt, output logic ok);
		logic [7:0] r;
		logic       a, b, c;
		st();
		xb({ad, 1'b0}, 1'b1, r, a);
		xb(ix, 1'b1, r, b);
		xb(dt, 1'b1, r, c);
		sp();
		ok = ~(a | b | c);
	endtask : wr
	// index, repeated start, one byte read ended by a nack
	task automatic rd(input logic [6:0] ad, input logic [7:0] ix, output logic [7:0] dt,
		output logic ok);
		logic [7:0] r;
		logic       a, b, c, n;
		st();
		xb({ad, 1'b0}, 1'b1, r, a);
		xb(ix, 1'b1, r, b);
		st();
		xb({ad, 1'b1}, 1'b1, r, c);
		xb(8'hff, 1'b1, dt, n);
		sp();
		ok = ~(a | b | c);
	endtask : rd
endmodule : rsc_i2c_master

// ==== rsc_startup_ctl_tb.sv ====
// Purpose: self-checking bench of the regulator start-up control
// Assumes: fault pins idle but for one trip; address ladder strapped for offset 2
// Notes:   fast ramp rate keeps the run short
module rsc_startup_ctl_tb
	import rsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0]  PID = 8'h3c;  // arbitrary identity value
	localparam logic [6:0]  ADR = 7'h0a;  // base 0x08 plus offset 2
	localparam logic [12:0] TGT = 13'h0b8 * VOUT_STEP_MV + VOUT_OFFSET_MV;
	logic            clk = 1'b0, linkClk = 1'b0, resetn = 1'b0;
	logic            bias = 1'b1, enable = 1'b0;  // start in lockout
	logic            trip = 1'b0;                 // both protection inputs
	logic [2:0]      addrCmp = 3'h3;              // 20k ladder
	logic [MV_W-1:0] sense = '0, refLvl;
	logic            scl, mOe_n, dOe_n, hs, ls, pgOe_n, busSel, ok;
	logic [7:0]      d;
	wire             sda = mOe_n & dOe_n;         // pull-up, any party pulls low
	int              errorCnt = 0, checksDone = 0;
	// clocks; link clock offset so the domains never line up
	always #20 clk = ~clk;
	initial begin
		#7;
		forever #80 linkClk = ~linkClk;
	end
	rsc_startup_ctl #(.PART_IDENTIFICATION(PID)) dut (.clk(clk), .resetn(resetn), .linkClk(linkClk),
		.biasUndervoltageLockout(bias), .enable(enable), .addrCmp(addrCmp), .ocpFault(trip),
		.ovpFault(trip), .outputSense(sense), .sclIn(scl), .sdaIn(sda), .sdaOut(),
		.sdaOe_n(dOe_n), .highSideDrive(hs), .lowSideDrive(ls), .refLevel(refLvl),
		.powerGoodOut(), .powerGoodOe_n(pgOe_n), .busLevelSel(busSel));
	rsc_i2c_master mst (.linkClk(linkClk), .sda(sda), .scl(scl), .sdaOe_n(mOe_n));
	// compare and count
	task automatic chk(input logic [12:0] got, exp);
		checksDone++;
		if (got !== exp) begin
			errorCnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic results();
		$display("checks %0d mismatches %0d", checksDone, errorCnt);
		if (errorCnt == 0 && checksDone > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	// a used-up wait bound is a mismatch and ends the run
	task automatic lim(input int n, m);
		if (n >= m) begin
			errorCnt++;
			results();
		end
	endtask : lim
	// lockout: quiet outputs, deaf bus
	task automatic tLock();
		@(negedge clk);
		chk(refLvl, '0);
		chk({hs, ls, pgOe_n, busSel}, '0);
		mst.rd(ADR, IDX_PART_IDENTIFICATION, d, ok);
		chk(ok, 1'b0);
		@(posedge clk);
		bias <= 1'b0;
		repeat (60) @(posedge clk);
		$display("lockout test done");
	endtask : tLock
	// register map over the bus
	task automatic tRegs();
		mst.rd(ADR, IDX_PART_IDENTIFICATION, d, ok);
		chk({ok, d}, {1'b1, PID});
		mst.wr(ADR, IDX_PART_IDENTIFICATION, 8'hff, ok);
		mst.rd(ADR, IDX_PART_IDENTIFICATION, d, ok);
		chk(d, PID);
		mst.rd(ADR, IDX_RAMP, d, ok);
		chk(d, 8'h00);
		mst.rd(ADR, IDX_STOP, d, ok);
		chk(d, 8'h00);
		mst.rd(ADR, IDX_BASE, d, ok);
		chk(d, 8'h08);
		mst.rd(ADR, 8'h30, d, ok);
		chk(d, 8'h00);
		mst.wr(7'h08, IDX_BUSLVL, 8'h02, ok);
		chk({ok, busSel}, 2'h0);
		mst.wr(ADR, IDX_BUSLVL, 8'h02, ok);
		repeat (10) @(negedge clk);
		chk(busSel, 1'b1);
		mst.wr(ADR, IDX_VOUT_HI, 8'h00, ok);
		mst.wr(ADR, IDX_VOUT_LO, 8'hb8, ok);
		mst.rd(ADR, IDX_VOUT_LO, d, ok);
		chk(d, 8'hb8);
		$display("register test done");
	endtask : tRegs
	// pre-biased ramp at 2 mV per step up to the target
	task automatic tRamp();
		int n = 0, cnt = 0, bad = 0, seen = 0, e;
		e = (TGT / 2 - 1) * RAMP_STEP_CYC + 1;
		mst.wr(ADR, IDX_RAMP, 8'h08, ok);
		mst.wr(ADR, IDX_STOP, 8'h08, ok);
		@(posedge clk);
		sense <= 13'h3e8;
		repeat (20) @(negedge clk);
		chk(refLvl, '0);
		@(posedge clk);
		enable <= 1'b1;
		while (refLvl !== TGT && n < 40000) begin
			@(negedge clk);
			n++;
			cnt += (refLvl !== '0);
			bad += (hs && refLvl <= sense) || pgOe_n;
			seen |= hs;
		end
		lim(n, 40000);
		chk(cnt >= e - 2 && cnt <= e + 2, 1'b1);
		chk({bad != 0, seen != 0}, 2'b01);
		repeat (5) @(negedge clk);
		chk(pgOe_n, 1'b1);
		$display("ramp test done");
	endtask : tRamp
	// graceful stop descends at the same rate; a trip or enable low cuts the drives
	task automatic tStop();
		int          n = 0;
		logic [12:0] lvl;
		mst.wr(ADR, IDX_RAMP, 8'h0c, ok);
		@(negedge clk);
		lvl = refLvl;
		// the descent may start mid-write, so line up on a step first
		while (refLvl === lvl && n < 100) begin
			@(negedge clk);
			n++;
		end
		lim(n, 100);
		lvl = refLvl;
		repeat (500) @(negedge clk);
		chk(lvl - refLvl, 13'h028);
		@(posedge clk);
		trip <= 1'b1;
		repeat (4) @(negedge clk);
		chk({hs, ls}, 2'b00);
		@(posedge clk);
		trip <= 1'b0;
		repeat (8) @(negedge clk);
		@(posedge clk);
		enable <= 1'b0;
		repeat (4) @(negedge clk);
		chk(refLvl, '0);
		chk({hs, ls}, 2'b00);
		$display("stop test done");
	endtask : tStop
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		tLock();
		tRegs();
		tRamp();
		tStop();
		results();
	end
endmodule : rsc_startup_ctl_tb
